// *** rtl/apc_regs.vh ***
/*
  timing counts and widths for the converter output control block.
  assumes: one sample clock at 25 MHz; included by bare name.
*/
`ifndef APC_REGS_VH
`define APC_REGS_VH

// ----------------------------------------------------------------
// data format
// ----------------------------------------------------------------
`define APC_CODE_W        8
`define APC_CODE_COUNT    256
`define APC_COARSE_W      4
`define APC_FINE_W        5

// ----------------------------------------------------------------
// pipeline timing
// ----------------------------------------------------------------
// 3 1/2 cycles: whole-cycle part plus a half-cycle hold on the falling edge
`define APC_PIPE_WHOLE    3
`define APC_SETTLE_CYC    4
`define APC_SETTLE_W      3
`define APC_FIFO_DEPTH    4

`endif

// *** rtl/apc_fifo.v ***
/*
  small synchronous fifo carrying finished result codes.
  assumes: single clock, async active-low reset; depth is a power of two.
*/
`timescale 1ns/1ps
module apc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  input  wire             flush_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign empty       = (wr_q == rd_q);
  assign full        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // apc_fifo

// *** rtl/apc_correct.v ***
/*
  merges coarse and fine comparator results into one corrected code.
  assumes: fine result carries one overlap bit above the code lsbs.
*/
`timescale 1ns/1ps
`include "apc_regs.vh"
module apc_correct (
  input  wire [`APC_COARSE_W-1:0] coarse_i,
  input  wire [`APC_FINE_W-1:0]   fine_i,
  output wire [`APC_CODE_W-1:0]   code_o
);

  // ----------------------------------------------------------------
  // overlap correction
  // ----------------------------------------------------------------
  // fine overlap bit carries into coarse; saturate at full scale
  wire [`APC_CODE_W:0] sum;
  assign sum    = {1'b0, coarse_i, 4'h0} + {4'h0, fine_i};
  assign code_o = sum[`APC_CODE_W] ? 8'hff : sum[`APC_CODE_W-1:0];

endmodule // apc_correct

// *** rtl/apc_core.v ***
/*
  digital side of an 8-bit two-step sampling converter: sample/hold timing,
  pipelined coarse/fine merge, three-state result drivers, power-down.
  assumes: sample clock clk_sys_i; comparator results arrive as inputs.
*/
`timescale 1ns/1ps
`include "apc_regs.vh"
module apc_core #(
  parameter CODE_W     = `APC_CODE_W,
  parameter SETTLE_CYC = `APC_SETTLE_CYC,
  parameter FIFO_DEPTH = `APC_FIFO_DEPTH
) (
  input  wire                     clk_sys_i,
  input  wire                     rst_n_i,
  input  wire                     out_en_n_i,
  input  wire                     pwr_down_req_i,
  input  wire [`APC_COARSE_W-1:0] coarse_i,
  input  wire [`APC_FINE_W-1:0]   fine_i,
  output wire [CODE_W-1:0]        result_o,
  output wire [CODE_W-1:0]        result_oe_o,
  output wire                     result_valid_o,
  output wire                     track_o,
  output wire                     hold_o,
  output wire                     pwr_down_o,
  output wire                     fifo_valid_o,
  input  wire                     fifo_ready_i,
  output wire [CODE_W-1:0]        fifo_data_o
);

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN    = 3'b001;
  localparam [2:0] ST_DOWN   = 3'b010;
  localparam [2:0] ST_SETTLE = 3'b100;

  reg [2:0]               st_q;
  reg [2:0]               st_d;
  reg [`APC_SETTLE_W-1:0] settle_q;
  reg [`APC_SETTLE_W-1:0] settle_d;

  always @* begin
    st_d     = st_q;
    settle_d = settle_q;
    case (st_q)
      ST_RUN: begin
        if (pwr_down_req_i) begin
          st_d = ST_DOWN;
        end
      end
      ST_DOWN: begin
        settle_d = {`APC_SETTLE_W{1'b0}};
        if (!pwr_down_req_i) begin
          st_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (pwr_down_req_i) begin
          st_d = ST_DOWN;
        end else if (settle_q == SETTLE_CYC[`APC_SETTLE_W-1:0] - 3'd1) begin
          st_d = ST_RUN;
        end else begin
          settle_d = settle_q + 3'd1;
        end
      end
      default: begin
        st_d = ST_DOWN;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= ST_SETTLE;
      settle_q <= {`APC_SETTLE_W{1'b0}};
    end else begin
      st_q     <= st_d;
      settle_q <= settle_d;
    end
  end

  wire down   = st_q[1];
  wire active = ~down;

  // ----------------------------------------------------------------
  // sample and hold
  // ----------------------------------------------------------------
  // hold latches on the falling edge; aperture delay itself is analog
  reg hold_q;
  always @(negedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= active;
    end
  end
  assign track_o = clk_sys_i & active;
  assign hold_o  = hold_q & ~clk_sys_i;

  // ----------------------------------------------------------------
  // conversion pipeline
  // ----------------------------------------------------------------
  // stage 1 coarse, stage 2 fine + merge, stage 3 output register;
  // with the falling-edge hold this gives 3 1/2 cycles
  reg [`APC_COARSE_W-1:0] coarse_q;
  reg [`APC_COARSE_W-1:0] coarse2_q;
  reg [`APC_FINE_W-1:0]   fine_q;
  reg [CODE_W-1:0]        result_q;
  reg [`APC_PIPE_WHOLE-1:0] vld_q;
  wire [CODE_W-1:0]       merged;

  apc_correct u_correct (
    .coarse_i (coarse2_q),
    .fine_i   (fine_q),
    .code_o   (merged)
  );

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coarse_q  <= {`APC_COARSE_W{1'b0}};
      coarse2_q <= {`APC_COARSE_W{1'b0}};
      fine_q    <= {`APC_FINE_W{1'b0}};
      result_q  <= {CODE_W{1'b0}};
      vld_q     <= {`APC_PIPE_WHOLE{1'b0}};
    end else if (down) begin
      vld_q <= {`APC_PIPE_WHOLE{1'b0}};
    end else begin
      // runs regardless of output enable
      coarse_q  <= coarse_i;
      coarse2_q <= coarse_q;
      fine_q    <= fine_i;
      result_q  <= merged;
      vld_q     <= {vld_q[`APC_PIPE_WHOLE-2:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------
  // enable assumed never floating, so no keeper here
  wire drive = ~out_en_n_i & ~down;
  assign result_o       = result_q;
  assign result_oe_o    = {CODE_W{drive}};
  assign result_valid_o = vld_q[`APC_PIPE_WHOLE-1] & st_q[0];
  assign pwr_down_o     = down;

  // ----------------------------------------------------------------
  // capture fifo
  // ----------------------------------------------------------------
  // full fifo drops codes: the converter cannot be stalled
  apc_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (down),
    .in_valid_i  (result_valid_o),
    .in_ready_o  (),
    .in_data_i   (result_q),
    .out_valid_o (fifo_valid_o),
    .out_ready_i (fifo_ready_i),
    .out_data_o  (fifo_data_o)
  );

endmodule // apc_core

// *** tb/apc_core_sva.sv ***
/* port assertions for the converter output control block.
   assumes: bound to apc_core; one sample clock, async low reset. */
`timescale 1ns/1ps
module apc_core_sva #(parameter CODE_W = 8) (
  input wire              clk_sys_i,
  input wire              rst_n_i,
  input wire              out_en_n_i,
  input wire              pwr_down_req_i,
  input wire [3:0]        coarse_i,
  input wire [4:0]        fine_i,
  input wire [CODE_W-1:0] result_o,
  input wire [CODE_W-1:0] result_oe_o,
  input wire              result_valid_o,
  input wire              track_o,
  input wire              hold_o,
  input wire              pwr_down_o
);
  // ------------------------------
  // port relations
  // ------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  function automatic [7:0] merge(input [3:0] c, input [4:0] f);
    reg [8:0] s;
    s = {1'b0, c, 4'h0} + f;
    merge = s[8] ? 8'hff : s[7:0];
  endfunction
  chk_oe_off: assert property (out_en_n_i |-> result_oe_o == 0)
    else $error("drivers on while disabled");
  chk_oe_on: assert property (!out_en_n_i && !pwr_down_o |-> &result_oe_o)
    else $error("drivers off while enabled");
  chk_pd_float: assert property (pwr_down_o |-> result_oe_o == 0 && !result_valid_o)
    else $error("output active in power-down");
  chk_pd_enter: assert property ($rose(pwr_down_req_i) |-> ##[0:1] pwr_down_o)
    else $error("power-down not entered");
  chk_settle_count: assert property ($fell(pwr_down_req_i) |-> !result_valid_o [*4])
    else $error("valid too soon after power-up");
  chk_code_merge: assert property (result_valid_o |->
    result_o == merge($past(coarse_i, 3), $past(fine_i, 2)))
    else $error("wrong code or latency");
  chk_one_per_cycle: assert property (result_valid_o && !pwr_down_req_i |=> result_valid_o)
    else $error("result stream gap");
  chk_track_phase: assert property (@(negedge clk_sys_i) !pwr_down_o |-> track_o && !hold_o)
    else $error("not tracking while clock high");
  chk_hold_phase: assert property (!pwr_down_o |-> hold_o && !track_o)
    else $error("not holding while clock low");
endmodule // apc_core_sva
bind apc_core apc_core_sva #(.CODE_W(CODE_W)) apc_core_sva_i (.clk_sys_i, .rst_n_i, .out_en_n_i,
  .pwr_down_req_i, .coarse_i, .fine_i, .result_o, .result_oe_o, .result_valid_o, .track_o, .hold_o, .pwr_down_o);

// *** tb/apc_host_model.sv ***
/* host logic taking finished codes from the result fifo.
   assumes: valid/ready on the sample clock; stall pattern from the bench. */
`timescale 1ns/1ps
module apc_host_model (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        stall_i,
  input  wire        valid_i,
  output reg         ready_o,
  output reg  [15:0] taken_o
);
  // only valid words reach the fifo, so settle-time codes are never taken
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
      taken_o <= 16'h0000;
    end else begin
      ready_o <= !stall_i;
      if (valid_i && ready_o) taken_o <= taken_o + 16'h0001;
    end
  end
endmodule // apc_host_model

// *** tb/adc_pipeline_output_ctrl_tb_top.sv ***
/* bench: random and corner codes, output enable, power-down, fifo stall.
   assumes: rtl include path is set for apc_regs.vh. */
`timescale 1ns/1ps
module adc_pipeline_output_ctrl_tb_top;
  reg         clk_sys_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         out_en_n_i = 1'b0;
  reg         pwr_down_req_i = 1'b0;
  reg  [3:0]  coarse_i = 4'h0;
  reg  [4:0]  fine_i = 5'h00;
  reg         stall = 1'b1;
  reg  [3:0]  c1, c2, c3;
  reg  [4:0]  f1, f2;
  reg  [31:0] seed = 32'hcc0a;
  wire [7:0]  result_o, result_oe_o, fifo_data_o;
  wire        result_valid_o, track_o, hold_o, pwr_down_o, fifo_valid_o, fifo_ready;
  wire [15:0] taken;
  integer     failures = 0, check_count = 0, since_up = 99, i, wp = 0, rp = 0;
  reg  [7:0]  expq [0:3];
  initial forever #20 clk_sys_i = ~clk_sys_i;
  apc_core apc_core_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .out_en_n_i(out_en_n_i),
    .pwr_down_req_i(pwr_down_req_i), .coarse_i(coarse_i), .fine_i(fine_i), .result_o(result_o),
    .result_oe_o(result_oe_o), .result_valid_o(result_valid_o), .track_o(track_o), .hold_o(hold_o),
    .pwr_down_o(pwr_down_o), .fifo_valid_o(fifo_valid_o), .fifo_ready_i(fifo_ready), .fifo_data_o(fifo_data_o));
  apc_host_model apc_host_model_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .valid_i(fifo_valid_o), .ready_o(fifo_ready), .taken_o(taken));
  // ------------------------------
  // expectation and compare
  // ------------------------------
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [7:0] merge(input [3:0] c, input [4:0] f);
    reg [8:0] s;
    begin
      s = {1'b0, c, 4'h0} + f;
      merge = s[8] ? 8'hff : s[7:0];
    end
  endfunction
  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // scoreboard sees pre-edge values, so the pipeline history lines up
  always @(posedge clk_sys_i) begin
    c1 <= coarse_i;
    c2 <= c1;
    c3 <= c2;
    f1 <= fine_i;
    f2 <= f1;
    since_up <= pwr_down_req_i ? 0 : since_up + 1;
    if (rst_n_i) begin
      check(result_oe_o, (out_en_n_i || pwr_down_o) ? 8'h00 : 8'hff);
      if (since_up < 4) check({7'h00, result_valid_o}, 8'h00);
      if (result_valid_o === 1'b1) check(result_o, merge(c3, f2));
      // fifo model: flushed while down, drops codes when four are waiting
      if (pwr_down_o === 1'b1) begin
        wp = 0;
        rp = 0;
      end else begin
        if (result_valid_o === 1'b1 && wp - rp < 4) begin
          expq[wp % 4] = merge(c3, f2);
          wp = wp + 1;
        end
        if (fifo_valid_o === 1'b1 && fifo_ready === 1'b1) begin
          check(fifo_data_o, expq[rp % 4]);
          rp = rp + 1;
        end
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 300; i = i + 1) begin
      @(posedge clk_sys_i);
      seed = lfsr(seed);
      {fine_i, coarse_i} <= (i < 100 || i >= 115) ? seed[8:0] :
        (i < 105) ? 9'h1ff : (i < 110) ? 9'h000 : 9'h107;
      out_en_n_i <= seed[9] & seed[10];
      stall <= (i < 40) ? 1'b1 : seed[11];
      pwr_down_req_i <= (i >= 200 && i < 220);
      if (i == 30) check({7'h00, fifo_valid_o}, 8'h01);
      if (i == 206) check({7'h00, pwr_down_o}, 8'h01);
      if (i == 212) check({7'h00, fifo_valid_o}, 8'h00);
      if (i == 240) check({7'h00, result_valid_o}, 8'h01);
    end
    check({7'h00, taken != 16'h0000}, 8'h01);
    close_out;
  end
  initial begin
    #(40 * 1000);
    failures = failures + 1;
    close_out;
  end
endmodule // adc_pipeline_output_ctrl_tb_top
